// ==== include/tcr_params.svh ====
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// Register select indices, in pulse-count order
`define TCR_SEL_LEVEL_COARSE 3'h0
`define TCR_SEL_LEVEL_FINE 3'h1
`define TCR_SEL_GAIN_COARSE 3'h2
`define TCR_SEL_GAIN_FINE 3'h3
`define TCR_SEL_TEMP_COEFF 3'h4
`define TCR_SEL_CLAMP 3'h5
`define TCR_SEL_POLARITY 3'h6
`define TCR_SEL_LOCK 3'h7
`define TCR_SEL_LAST 3'h6

// Mode select counter values
`define TCR_MODE_NONE 2'h0
`define TCR_MODE_TRY 2'h1
`define TCR_MODE_BLOW 2'h2
`define TCR_MODE_LOCK 2'h3

// Field widths
`define TCR_W_COARSE 2
`define TCR_W_LEVEL_FINE 9
`define TCR_W_GAIN_FINE 8
`define TCR_W_TEMP_COEFF 5
`define TCR_W_FUSE_BITS 9

// Coarse codes: last legal code before wrap
`define TCR_COARSE_LAST 2'h2
`define TCR_COARSE_0 2'h0
`define TCR_COARSE_1 2'h1
`define TCR_COARSE_2 2'h2

// Temperature coefficient code map
`define TCR_TC_NEG_BIT 4
`define TCR_TC_ALIAS_FIRST 4'hC
`define TCR_TC_ALIAS_SHIFT 4'h8
`define TCR_TC_NEG_BASE 4'h1

`endif

// ==== include/tcr_pkg.sv ====
package tcr_pkg;

  typedef enum logic [1:0] {TCR_ST_INIT, TCR_ST_MODE, TCR_ST_REG, TCR_ST_BITS} tcr_phase_t;
  typedef enum logic [1:0] {TCR_RANGE_LOW, TCR_RANGE_MID, TCR_RANGE_HIGH} tcr_range_t;
  typedef enum logic [1:0] {TCR_CLAMP_NONE, TCR_CLAMP_HALF_V, TCR_CLAMP_ONE_V} tcr_clamp_t;

  typedef struct packed {
    tcr_phase_t phase;
    logic [1:0] mode;
    logic [2:0] sel;
    logic [1:0] lvl_c;
    logic [8:0] lvl_f;
    logic [1:0] gn_c;
    logic [7:0] gn_f;
    logic [4:0] tc;
    logic [1:0] clamp;
    logic pol;
    logic lock;
    tcr_range_t level_range;
    logic [8:0] fine_level;
    tcr_range_t gain_range;
    logic [7:0] fine_gain;
    logic tc_negative;
    logic [3:0] tc_step;
    tcr_clamp_t clamp_out;
    logic north_rising;
    logic locked;
    logic fuse_blow;
    logic [2:0] fuse_reg;
    logic [8:0] fuse_bits;
  } tcr_state_t;

endpackage

// ==== design/tcr_trim_decode.sv ====
// Operation
// [RQ1] Coarse level code 0 mid, 1 low, 2 high range.
// [RQ2] Coarse level, coarse gain and clamp wrap from code 2 to 0.
// [RQ3] Fine level holds codes 0 to 511 within the coarse range.
// [RQ4] Coarse gain code 0 low, 1 mid, 2 high range.
// [RQ5] Fine gain holds codes 0 to 255 within the coarse range.
// [RQ6] Coefficient code 0 initial, codes 1 to 11 positive steps.
// [RQ7] Coefficient codes 12 to 15 act as codes 4 to 7.
// [RQ8] Codes 16 to 27 negative; code 16 one step below initial.
// [RQ9] Coefficient codes 28 to 31 act as codes 20 to 23.
// [RQ10] Clamp code 0 none, 1 half volt, 2 one volt inside rails.
// [RQ11] Polarity 0 rises for south field, 1 rises for north field.
// [RQ12] Lock bit 0 unlocked, 1 locked.
// [RQ13] Mode pulse count: one trial, two fuse commit, three lock.
// [RQ14] Register pulse count picks level, gain, coefficient, clamp, polarity.
// [RQ15] Trial mode: each low pulse increments selected register by one.
// [RQ16] Entering bitfield selection clears intact bits of selected register.
// [RQ17] Fine and coefficient registers wrap to zero past all ones.
// [RQ18] Effective value ORs blown fuse bits with provisional bits.
`timescale 1ns/100ps
`include "tcr_params.svh"
module tcr_trim_decode
  import tcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_low_level_pulse,
  input wire logic i_high_level_pulse,
  input wire logic [1:0] i_fuse_lvl_c,
  input wire logic [8:0] i_fuse_lvl_f,
  input wire logic [1:0] i_fuse_gn_c,
  input wire logic [7:0] i_fuse_gn_f,
  input wire logic [4:0] i_fuse_tc,
  input wire logic [1:0] i_fuse_clamp,
  input wire logic i_fuse_pol,
  input wire logic i_fuse_lock,
  output tcr_range_t o_level_range,
  output logic [8:0] o_fine_level,
  output tcr_range_t o_gain_range,
  output logic [7:0] o_fine_gain,
  output logic o_tc_negative,
  output logic [3:0] o_tc_step,
  output tcr_clamp_t o_clamp,
  output logic o_north_rising,
  output logic o_locked,
  output logic o_fuse_blow,
  output logic [2:0] o_fuse_reg,
  output logic [8:0] o_fuse_bits
);

  tcr_state_t cur;
  tcr_state_t next_cur;
  logic [1:0] e_lvl_c;
  logic [8:0] e_lvl_f;
  logic [1:0] e_gn_c;
  logic [7:0] e_gn_f;
  logic [4:0] e_tc;
  logic [1:0] e_clamp;
  logic e_pol;
  logic e_lock;

  // Coarse increment skips code 3
  function automatic logic [1:0] inc_coarse(input logic [1:0] v);
    inc_coarse = (v >= `TCR_COARSE_LAST) ? `TCR_COARSE_0 : 2'(v + 2'h1); // RQ2
  endfunction

  // Coarse code to range; code 3 (only reachable by fuses) reads as code 0
  function automatic tcr_range_t dec_range(input logic [1:0] v, input logic gain);
    case (v)
      `TCR_COARSE_1: dec_range = gain ? TCR_RANGE_MID : TCR_RANGE_LOW;
      `TCR_COARSE_2: dec_range = TCR_RANGE_HIGH;
      default: dec_range = gain ? TCR_RANGE_LOW : TCR_RANGE_MID;
    endcase
  endfunction

  // Effective values: a blown fuse always reads one
  always_comb begin
    e_lvl_c = cur.lvl_c | i_fuse_lvl_c; // RQ18
    e_lvl_f = cur.lvl_f | i_fuse_lvl_f; // RQ18
    e_gn_c = cur.gn_c | i_fuse_gn_c;
    e_gn_f = cur.gn_f | i_fuse_gn_f;
    e_tc = cur.tc | i_fuse_tc;
    e_clamp = cur.clamp | i_fuse_clamp;
    e_pol = cur.pol | i_fuse_pol;
    e_lock = cur.lock | i_fuse_lock;
  end

  // Sequencer, provisional bits and registered decode
  always_comb begin
    logic [3:0] tc_low;
    next_cur = cur;
    tc_low = e_tc[3:0];
    next_cur.fuse_blow = 1'b0;
    case (cur.phase)
      TCR_ST_INIT: begin
        // Low pulses ignored here; a blown lock fuse keeps the sequencer in this state, later phases do not check it
        if (i_high_level_pulse && !i_fuse_lock) begin
          next_cur.phase = TCR_ST_MODE;
          next_cur.mode = `TCR_MODE_NONE;
        end
      end
      TCR_ST_MODE: begin
        if (i_low_level_pulse) begin
          next_cur.mode = 2'(cur.mode + 2'h1); // RQ13
        end else if (i_high_level_pulse && cur.mode != `TCR_MODE_NONE) begin
          if (cur.mode == `TCR_MODE_LOCK) begin
            // Lock mode has no register step
            next_cur.phase = TCR_ST_BITS; // RQ13
            next_cur.sel = `TCR_SEL_LOCK;
            next_cur.lock = 1'b0;
          end else begin
            next_cur.phase = TCR_ST_REG;
            next_cur.sel = `TCR_SEL_LEVEL_COARSE;
          end
        end
      end
      TCR_ST_REG: begin
        if (i_low_level_pulse) begin
          next_cur.sel = (cur.sel == `TCR_SEL_LAST) ? `TCR_SEL_LEVEL_COARSE
                                                    : 3'(cur.sel + 3'h1); // RQ14
        end else if (i_high_level_pulse) begin
          next_cur.phase = TCR_ST_BITS;
          // Blown bits survive because they live in the fuses
          case (cur.sel)
            `TCR_SEL_LEVEL_COARSE: next_cur.lvl_c = '0; // RQ16
            `TCR_SEL_LEVEL_FINE: next_cur.lvl_f = '0;
            `TCR_SEL_GAIN_COARSE: next_cur.gn_c = '0;
            `TCR_SEL_GAIN_FINE: next_cur.gn_f = '0;
            `TCR_SEL_TEMP_COEFF: next_cur.tc = '0; // RQ16
            `TCR_SEL_CLAMP: next_cur.clamp = '0;
            default: next_cur.pol = 1'b0;
          endcase
        end
      end
      TCR_ST_BITS: begin
        if (i_low_level_pulse) begin
          // Increment the effective code so blown bits count
          case (cur.sel)
            `TCR_SEL_LEVEL_COARSE: next_cur.lvl_c = inc_coarse(e_lvl_c); // RQ15 RQ2
            `TCR_SEL_LEVEL_FINE: next_cur.lvl_f = 9'(e_lvl_f + 9'h001); // RQ3 RQ17
            `TCR_SEL_GAIN_COARSE: next_cur.gn_c = inc_coarse(e_gn_c); // RQ2
            `TCR_SEL_GAIN_FINE: next_cur.gn_f = 8'(e_gn_f + 8'h01); // RQ5 RQ17
            `TCR_SEL_TEMP_COEFF: next_cur.tc = 5'(e_tc + 5'h01); // RQ17
            `TCR_SEL_CLAMP: next_cur.clamp = inc_coarse(e_clamp); // RQ2
            `TCR_SEL_POLARITY: next_cur.pol = ~e_pol;
            default: next_cur.lock = ~e_lock; // RQ12
          endcase
        end else if (i_high_level_pulse) begin
          next_cur.phase = TCR_ST_MODE;
          next_cur.mode = `TCR_MODE_NONE;
          // Commit modes ask for the not yet blown bits to be burnt
          if (cur.mode != `TCR_MODE_TRY) begin
            next_cur.fuse_blow = 1'b1;
            next_cur.fuse_reg = cur.sel;
            case (cur.sel)
              `TCR_SEL_LEVEL_COARSE: next_cur.fuse_bits = 9'(cur.lvl_c & ~i_fuse_lvl_c);
              `TCR_SEL_LEVEL_FINE: next_cur.fuse_bits = cur.lvl_f & ~i_fuse_lvl_f;
              `TCR_SEL_GAIN_COARSE: next_cur.fuse_bits = 9'(cur.gn_c & ~i_fuse_gn_c);
              `TCR_SEL_GAIN_FINE: next_cur.fuse_bits = 9'(cur.gn_f & ~i_fuse_gn_f);
              `TCR_SEL_TEMP_COEFF: next_cur.fuse_bits = 9'(cur.tc & ~i_fuse_tc);
              `TCR_SEL_CLAMP: next_cur.fuse_bits = 9'(cur.clamp & ~i_fuse_clamp);
              `TCR_SEL_POLARITY: next_cur.fuse_bits = 9'(cur.pol & ~i_fuse_pol);
              default: next_cur.fuse_bits = 9'(cur.lock & ~i_fuse_lock);
            endcase
          end
        end
      end
      default: next_cur.phase = TCR_ST_INIT;
    endcase
    // Decode of the effective codes, one cycle behind them
    next_cur.level_range = dec_range(e_lvl_c, 1'b0); // RQ1
    next_cur.fine_level = e_lvl_f; // RQ3
    next_cur.gain_range = dec_range(e_gn_c, 1'b1); // RQ4
    next_cur.fine_gain = e_gn_f; // RQ5
    // Alias codes fold down by eight before the step is taken
    if (tc_low >= `TCR_TC_ALIAS_FIRST) begin
      tc_low = 4'(tc_low - `TCR_TC_ALIAS_SHIFT); // RQ7 RQ9
    end
    next_cur.tc_negative = e_tc[`TCR_TC_NEG_BIT]; // RQ8
    next_cur.tc_step = e_tc[`TCR_TC_NEG_BIT] ? 4'(tc_low + `TCR_TC_NEG_BASE)
                                             : tc_low; // RQ6 RQ8
    case (e_clamp)
      `TCR_COARSE_1: next_cur.clamp_out = TCR_CLAMP_HALF_V; // RQ10
      `TCR_COARSE_2: next_cur.clamp_out = TCR_CLAMP_ONE_V;
      default: next_cur.clamp_out = TCR_CLAMP_NONE;
    endcase
    next_cur.north_rising = e_pol; // RQ11
    next_cur.locked = e_lock; // RQ12
  end

  // State register; power-up clears every provisional bit
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      cur <= '0;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state flops
  assign o_level_range = cur.level_range;
  assign o_fine_level = cur.fine_level;
  assign o_gain_range = cur.gain_range;
  assign o_fine_gain = cur.fine_gain;
  assign o_tc_negative = cur.tc_negative;
  assign o_tc_step = cur.tc_step;
  assign o_clamp = cur.clamp_out;
  assign o_north_rising = cur.north_rising;
  assign o_locked = cur.locked;
  assign o_fuse_blow = cur.fuse_blow;
  assign o_fuse_reg = cur.fuse_reg;
  assign o_fuse_bits = cur.fuse_bits;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_mode_wrap;
    cur.phase == TCR_ST_MODE && i_ce && i_low_level_pulse && cur.mode == `TCR_MODE_LOCK
      |=> cur.mode == `TCR_MODE_NONE;
  endproperty
  a_mode_wrap: assert property (p_mode_wrap) else $error("mode count did not wrap"); // RQ13

  property p_reg_wrap;
    cur.phase == TCR_ST_REG && i_ce && i_low_level_pulse && cur.sel == `TCR_SEL_LAST
      |=> cur.sel == `TCR_SEL_LEVEL_COARSE;
  endproperty
  a_reg_wrap: assert property (p_reg_wrap) else $error("register select did not wrap"); // RQ14

  property p_coarse_wrap;
    cur.phase == TCR_ST_BITS && i_ce && i_low_level_pulse && cur.sel == `TCR_SEL_CLAMP
      && e_clamp == `TCR_COARSE_2 |=> cur.clamp == `TCR_COARSE_0;
  endproperty
  a_coarse_wrap: assert property (p_coarse_wrap) else $error("clamp code took 3"); // RQ2

  property p_clear_entry;
    cur.phase == TCR_ST_REG && i_ce && i_high_level_pulse && !i_low_level_pulse
      && cur.sel == `TCR_SEL_TEMP_COEFF |=> cur.phase == TCR_ST_BITS && cur.tc == 5'h00;
  endproperty
  a_clear_entry: assert property (p_clear_entry) else $error("selected register not cleared"); // RQ16

  property p_fine_inc;
    cur.phase == TCR_ST_BITS && i_ce && i_low_level_pulse && cur.sel == `TCR_SEL_GAIN_FINE
      && i_fuse_gn_f == 8'h00 |=> cur.gn_f == 8'($past(cur.gn_f) + 8'h01);
  endproperty
  a_fine_inc: assert property (p_fine_inc) else $error("fine gain not incremented"); // RQ15

  property p_level_wrap;
    cur.phase == TCR_ST_BITS && i_ce && i_low_level_pulse && cur.sel == `TCR_SEL_LEVEL_FINE
      && e_lvl_f == 9'h1FF |=> cur.lvl_f == 9'h000;
  endproperty
  a_level_wrap: assert property (p_level_wrap) else $error("fine level did not wrap"); // RQ17

  property p_level_dec;
    i_ce && e_lvl_c == `TCR_COARSE_1 |=> o_level_range == TCR_RANGE_LOW;
  endproperty
  a_level_dec: assert property (p_level_dec) else $error("level code 1 not low range"); // RQ1

  property p_gain_dec;
    i_ce && e_gn_c == `TCR_COARSE_0 |=> o_gain_range == TCR_RANGE_LOW;
  endproperty
  a_gain_dec: assert property (p_gain_dec) else $error("gain code 0 not low range"); // RQ4

  property p_tc_pos_alias;
    i_ce && e_tc == 5'h0D |=> !o_tc_negative && o_tc_step == 4'h5;
  endproperty
  a_tc_pos_alias: assert property (p_tc_pos_alias) else $error("code 13 not as code 5"); // RQ7

  property p_tc_neg;
    i_ce && e_tc == 5'h10 |=> o_tc_negative && o_tc_step == 4'h1;
  endproperty
  a_tc_neg: assert property (p_tc_neg) else $error("code 16 not one step below"); // RQ8

  property p_tc_neg_alias;
    i_ce && e_tc == 5'h1D |=> o_tc_negative && o_tc_step == 4'h6;
  endproperty
  a_tc_neg_alias: assert property (p_tc_neg_alias) else $error("code 29 not as code 21"); // RQ9

  property p_clamp_dec;
    i_ce && e_clamp == `TCR_COARSE_2 |=> o_clamp == TCR_CLAMP_ONE_V;
  endproperty
  a_clamp_dec: assert property (p_clamp_dec) else $error("clamp code 2 misdecoded"); // RQ10

  property p_fuse_one;
    i_ce && i_fuse_lvl_f[0] |=> o_fine_level[0];
  endproperty
  a_fuse_one: assert property (p_fuse_one) else $error("blown bit read as zero"); // RQ18

  property p_lock_blocks;
    cur.phase == TCR_ST_INIT && i_ce && i_fuse_lock |=> cur.phase == TCR_ST_INIT;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked device left idle"); // RQ12

  c_try_cycle: cover property (cur.phase == TCR_ST_BITS && cur.mode == `TCR_MODE_TRY
    && i_ce && i_high_level_pulse ##1 cur.phase == TCR_ST_MODE);
  c_blow: cover property (o_fuse_blow && o_fuse_reg == `TCR_SEL_TEMP_COEFF);
  c_lock: cover property (o_fuse_blow && o_fuse_reg == `TCR_SEL_LOCK);

endmodule

// ==== tb/tcr_programmer_model.sv ====
`timescale 1ns/100ps
// External programmer: turns pulse counts into one-cycle detected pulses
module tcr_programmer_model (
  input wire logic i_core_clk,
  output logic o_low_level_pulse,
  output logic o_high_level_pulse
);
  int gap = 0; // Idle cycles between pulses, models a slow programmer

  initial begin
    o_low_level_pulse = 1'b0;
    o_high_level_pulse = 1'b0;
  end

  // One high pulse; returns just after the edge that takes it
  task automatic high();
    repeat (gap) @(posedge i_core_clk);
    @(posedge i_core_clk);
    #1 o_high_level_pulse = 1'b1;
    @(posedge i_core_clk);
    #1 o_high_level_pulse = 1'b0;
  endtask

  // Count of low pulses picks mode, register or code step
  task automatic lows(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_core_clk);
      #1 o_low_level_pulse = 1'b1;
      if (gap > 0) begin
        @(posedge i_core_clk);
        #1 o_low_level_pulse = 1'b0;
        repeat (gap - 1) @(posedge i_core_clk);
      end
    end
    // Back to back pulses stay high until the last is taken
    if (gap == 0 && n > 0) begin
      @(posedge i_core_clk);
      #1 o_low_level_pulse = 1'b0;
    end
  endtask
endmodule

// ==== tb/tb_trim_code_register_decode.sv ====
`timescale 1ns/100ps
`include "tcr_params.svh"
module tb_trim_code_register_decode;
  import tcr_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic low_p, high_p;
  logic [1:0] f_lc = 2'h0, f_gc = 2'h0, f_cl = 2'h0;
  logic [8:0] f_lf = 9'h000;
  logic [7:0] f_gf = 8'h00;
  logic [4:0] f_tc = 5'h00;
  logic f_pol = 1'b0, f_lock = 1'b0;
  tcr_range_t lvl_r, gn_r;
  tcr_clamp_t clamp;
  logic [8:0] fine_lvl, fuse_bits;
  logic [7:0] fine_gn;
  logic tc_neg, north, locked, blow;
  logic [3:0] tc_step;
  logic [2:0] fuse_reg;
  int miscompares = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  tcr_programmer_model u_prog (.i_core_clk(clk), .o_low_level_pulse(low_p),
    .o_high_level_pulse(high_p));

  tcr_trim_decode dut (.i_core_clk(clk), .i_resetn(resetn), .i_ce(ce),
    .i_low_level_pulse(low_p), .i_high_level_pulse(high_p), .i_fuse_lvl_c(f_lc),
    .i_fuse_lvl_f(f_lf), .i_fuse_gn_c(f_gc), .i_fuse_gn_f(f_gf), .i_fuse_tc(f_tc),
    .i_fuse_clamp(f_cl), .i_fuse_pol(f_pol), .i_fuse_lock(f_lock),
    .o_level_range(lvl_r), .o_fine_level(fine_lvl), .o_gain_range(gn_r),
    .o_fine_gain(fine_gn), .o_tc_negative(tc_neg), .o_tc_step(tc_step),
    .o_clamp(clamp), .o_north_rising(north), .o_locked(locked), .o_fuse_blow(blow),
    .o_fuse_reg(fuse_reg), .o_fuse_bits(fuse_bits));

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Power cycle: clears every provisional bit
  task automatic do_reset();
    @(posedge clk);
    #1 resetn = 1'b0;
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
  endtask

  // Decoded outputs lag the taking edge by one enabled edge
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Walk to bitfield stage; lock mode skips register select
  task automatic enter(input bit idle, input int mode, input logic [2:0] sel);
    if (idle) u_prog.high();
    u_prog.lows(mode);
    u_prog.high();
    if (mode != 3) begin
      u_prog.lows(int'(sel));
      u_prog.high();
    end
  endtask

  // Expected coefficient sign and step for a code
  function automatic logic [4:0] tc_exp(input logic [4:0] c);
    logic [4:0] a;
    a = (c >= 5'h1C || (c >= 5'h0C && c <= 5'h0F)) ? c - 5'h08 : c;
    return a[4] ? {1'b1, 4'(a - 5'h0F)} : {1'b0, a[3:0]};
  endfunction

  // Coarse registers: three codes then wrap to the first
  task automatic t_coarse(input logic [2:0] sel);
    logic [1:0] exp [4];
    logic [1:0] seen;
    // Level range codes run mid, low, high; gain and clamp run upwards
    if (sel == `TCR_SEL_LEVEL_COARSE) exp = '{2'h1, 2'h0, 2'h2, 2'h1};
    else exp = '{2'h0, 2'h1, 2'h2, 2'h0};
    do_reset();
    enter(1'b1, 1, sel);
    for (int k = 0; k < 4; k++) begin
      settle();
      if (sel == `TCR_SEL_LEVEL_COARSE) seen = lvl_r;
      else if (sel == `TCR_SEL_GAIN_COARSE) seen = gn_r;
      else seen = clamp;
      check(9'(seen), 9'(exp[k]));
      u_prog.lows(1);
    end
  endtask

  // Fine registers run to all ones and wrap, pulses back to back
  task automatic t_fine();
    do_reset();
    enter(1'b1, 1, `TCR_SEL_LEVEL_FINE);
    u_prog.lows(511);
    settle();
    check(fine_lvl, 9'h1FF);
    u_prog.lows(1);
    settle();
    check(fine_lvl, 9'h000);
    do_reset();
    enter(1'b1, 1, `TCR_SEL_GAIN_FINE);
    u_prog.lows(255);
    settle();
    check(9'(fine_gn), 9'h0FF);
    u_prog.lows(1);
    settle();
    check(9'(fine_gn), 9'h000);
  endtask

  // Every coefficient code with a slow programmer, then wrap
  task automatic t_tc();
    u_prog.gap = 2;
    do_reset();
    enter(1'b1, 1, `TCR_SEL_TEMP_COEFF);
    for (int c = 0; c < 33; c++) begin
      settle();
      check(9'({tc_neg, tc_step}), 9'(tc_exp(5'(c))));
      u_prog.lows(1);
    end
    u_prog.gap = 0;
  endtask

  task automatic t_pol();
    do_reset();
    enter(1'b1, 1, `TCR_SEL_POLARITY);
    settle();
    check(9'(north), 9'h000);
    u_prog.lows(1);
    settle();
    check(9'(north), 9'h001);
    check(9'(lvl_r), 9'(TCR_RANGE_MID));
  endtask

  // Re-entry clears provisional bits but keeps a blown one
  task automatic t_fuse_clear();
    f_tc = 5'h04;
    do_reset();
    enter(1'b1, 1, `TCR_SEL_TEMP_COEFF);
    u_prog.lows(3);
    u_prog.high();
    enter(1'b0, 1, `TCR_SEL_TEMP_COEFF);
    settle();
    check(9'(tc_step), 9'h004);
    u_prog.lows(2);
    settle();
    check(9'(tc_step), 9'h006);
    f_tc = 5'h00;
  endtask

  task automatic t_blow();
    do_reset();
    enter(1'b1, 2, `TCR_SEL_TEMP_COEFF);
    u_prog.lows(4);
    u_prog.high();
    check(9'(blow), 9'h001);
    check(9'(fuse_reg), 9'(`TCR_SEL_TEMP_COEFF));
    check(fuse_bits, 9'h004);
    @(posedge clk);
    #1 check(9'(blow), 9'h000);
  endtask

  // Lock request, then a lock-blown device ignores programming
  task automatic t_lock();
    do_reset();
    enter(1'b1, 3, 3'h0);
    u_prog.lows(1);
    settle();
    check(9'(locked), 9'h001);
    u_prog.high();
    check(9'(blow), 9'h001);
    check(9'(fuse_reg), 9'(`TCR_SEL_LOCK));
    f_lock = 1'b1;
    do_reset();
    enter(1'b1, 1, `TCR_SEL_LEVEL_COARSE);
    u_prog.lows(1);
    settle();
    check(9'(locked), 9'h001);
    check(9'(lvl_r), 9'(TCR_RANGE_MID));
    f_lock = 1'b0;
  endtask

  // Blown fuses read as ones; pulses and fuse changes are frozen while disabled
  task automatic t_fuse_freeze();
    do_reset();
    f_lc = 2'h1;
    f_lf = 9'h101;
    f_gc = 2'h2;
    f_gf = 8'h80;
    f_cl = 2'h1;
    f_pol = 1'b1;
    enter(1'b1, 1, `TCR_SEL_LEVEL_FINE);
    settle();
    check(9'(lvl_r), 9'(TCR_RANGE_LOW));
    check(fine_lvl, 9'h101);
    check(9'(gn_r), 9'(TCR_RANGE_HIGH));
    check(9'(fine_gn), 9'h080);
    check(9'(clamp), 9'(TCR_CLAMP_HALF_V));
    check(9'(north), 9'h001);
    ce = 1'b0;
    f_pol = 1'b0;
    u_prog.lows(2);
    settle();
    check(fine_lvl, 9'h101);
    check(9'(north), 9'h001);
    ce = 1'b1;
    u_prog.lows(1);
    settle();
    check(fine_lvl, 9'h103);
    check(9'(north), 9'h000);
    {f_lc, f_lf, f_gc, f_gf, f_cl, f_pol} = '0;
  endtask

  initial begin
    do_reset();
    settle();
    check(9'(lvl_r), 9'(TCR_RANGE_MID));
    t_coarse(`TCR_SEL_LEVEL_COARSE);
    t_coarse(`TCR_SEL_GAIN_COARSE);
    t_coarse(`TCR_SEL_CLAMP);
    t_fine();
    t_tc();
    t_pol();
    t_fuse_clear();
    t_blow();
    t_lock();
    t_fuse_freeze();
    finish_test();
  end

  // Run needs about 1300 cycles; cut a hang well beyond that
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule
